/* rtl/resistance_freq_converter.sv */
// One channel of the resistance-to-frequency converter: APB registers,
// clock selection, oscillation control, counters and cause flags.
// Assumes oscillator ticks and pin levels are synchronous to i_clk.
//
// Behaviour
// - debug-run bit 1 keeps operating clock in debug mode; 0 withholds it
// - source field picks internal, low-speed, high-speed or external clock
// - internal and high-speed sources divide 1,2,4,8; others undivided
// - monitor pin carries oscillation clock, halved if monitor-rate bit set
// - continuous bit disables automatic stops; only software stops
// - event-count bit selects external clock input mode
// - input pin pulled to ground when switched to converter function
// - mode field: 0 DC sensor mode, 1 AC sensor mode, rest reserved
// - enable bit supplies operating clock and enables operation
// - disabling mid-conversion may lose counts; conversion not resumable
// - trigger bits start/stop oscillation and read back running status
// - sensor B trigger does not start in AC mode
// - trigger writes have no effect while converter disabled
// - 24-bit measurement counter readable, writable, split low/high, reset 0
// - 24-bit time base counter readable, writable, split low/high, reset 0
// - five cause flags clear by writing 1
// - reference: both count up, wraps stop with done or overflow flag
// - sensor: measurement up from 0, time base down, zero ends it
// - interrupt request follows any set enabled flag one cycle later
// - sensor time base decrements from value left by reference run
`timescale 1ns/1ns
`include "rfc_regs.svh"
`default_nettype none

module resistance_freq_converter (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`RFC_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  input  wire logic                   i_debug_mode,
  input  wire logic                   i_internal_osc_tick,
  input  wire logic                   i_low_speed_osc_tick,
  input  wire logic                   i_high_speed_osc_tick,
  input  wire logic                   i_ext_clock_tick,
  input  wire logic                   i_cr_osc,
  input  wire logic                   i_converter_pin,
  input  wire logic                   i_pin_func_sel,
  output logic                        o_osc_monitor,
  output rfc_pkg::osc_drive_t         o_osc_drive,
  output logic                        o_pin_pulldown,
  output logic                        o_irq
);

  // Configuration, run state, counter, flag and output registers with next values
  logic                  debug_run_enable_q;
  logic [1:0]            clock_divider_sel_q;
  rfc_pkg::clk_src_t     clock_source_sel_q;
  logic                  monitor_half_rate_q;
  logic                  continuous_osc_enable_q;
  logic                  event_count_enable_q;
  rfc_pkg::osc_mode_t    oscillation_mode_sel_q;
  logic                  converter_enable_q;
  logic                  converter_enable_d;
  rfc_pkg::run_state_t   state_q;
  rfc_pkg::run_state_t   state_d;
  logic [23:0]           meas_q;
  logic [23:0]           meas_d;
  logic [23:0]           tb_q;
  logic [23:0]           tb_d;
  logic [`RFC_NFLAGS-1:0] flags_q;
  logic [`RFC_NFLAGS-1:0] flag_set;
  logic [`RFC_NFLAGS-1:0] int_en_q;
  logic [2:0]            div_q;
  logic [2:0]            div_mask;
  logic                  cr_prev_q;
  logic                  half_q;
  logic [31:0]           prdata_q;
  logic [31:0]           rd_d;
  logic                  monitor_q;
  rfc_pkg::osc_drive_t   drive_q;
  logic                  pulldown_q;
  logic                  irq_q;

  // Bus decode
  wire access   = i_psel & i_penable;
  wire setup    = i_psel & ~i_penable;
  wire wr       = access & i_pwrite;
  wire sel_clk  = i_paddr == `RFC_OFF_CLOCK_CFG;
  wire sel_ctl  = i_paddr == `RFC_OFF_CONV_CTL;
  wire sel_trg  = i_paddr == `RFC_OFF_OSC_TRIG;
  wire sel_mcl  = i_paddr == `RFC_OFF_MEAS_LOW;
  wire sel_mch  = i_paddr == `RFC_OFF_MEAS_HIGH;
  wire sel_tcl  = i_paddr == `RFC_OFF_TB_LOW;
  wire sel_tch  = i_paddr == `RFC_OFF_TB_HIGH;
  wire sel_intf = i_paddr == `RFC_OFF_INT_FLAGS;
  wire sel_inte = i_paddr == `RFC_OFF_INT_ENABLES;
  wire mapped   = sel_clk | sel_ctl | sel_trg | sel_mcl | sel_mch |
                  sel_tcl | sel_tch | sel_intf | sel_inte;
  wire wr_clk   = wr & sel_clk & ~converter_enable_q;
  wire wr_ctl   = wr & sel_ctl;
  wire wr_trg   = wr & sel_trg;
  wire wr_mcl   = wr & sel_mcl;
  wire wr_mch   = wr & sel_mch;
  wire wr_tcl   = wr & sel_tcl;
  wire wr_tch   = wr & sel_tch;
  wire wr_intf  = wr & sel_intf;
  wire wr_inte  = wr & sel_inte;

  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~mapped;
  assign o_prdata  = prdata_q;

  // Operating clock: source select, divider and gating
  wire src_tick =
    (clock_source_sel_q == rfc_pkg::SRC_INTERNAL)   ? i_internal_osc_tick :
    (clock_source_sel_q == rfc_pkg::SRC_LOW_SPEED)  ? i_low_speed_osc_tick :
    (clock_source_sel_q == rfc_pkg::SRC_HIGH_SPEED) ? i_high_speed_osc_tick :
                                                      i_ext_clock_tick;
  wire src_divisible = (clock_source_sel_q == rfc_pkg::SRC_INTERNAL) |
                       (clock_source_sel_q == rfc_pkg::SRC_HIGH_SPEED);
  assign div_mask = ~src_divisible               ? `RFC_DIV_MASK1 :
                    (clock_divider_sel_q == 2'h0) ? `RFC_DIV_MASK1 :
                    (clock_divider_sel_q == 2'h1) ? `RFC_DIV_MASK2 :
                    (clock_divider_sel_q == 2'h2) ? `RFC_DIV_MASK4 :
                                                    `RFC_DIV_MASK8;
  wire clk_run = converter_enable_q &
                 (~i_debug_mode | debug_run_enable_q);
  wire op_tick = clk_run & src_tick & ((div_q & div_mask) == div_mask);

  // Oscillation clock source and edge
  wire cr_level = event_count_enable_q ? i_converter_pin : i_cr_osc;
  wire cr_tick  = clk_run & cr_level & ~cr_prev_q;

  // Run state decode
  wire st_ref  = state_q == rfc_pkg::ST_REF;
  wire st_sa   = state_q == rfc_pkg::ST_SENS_A;
  wire st_sb   = state_q == rfc_pkg::ST_SENS_B;
  wire st_sens = st_sa | st_sb;
  wire running = st_ref | st_sens;
  wire auto_stop_ok = ~continuous_osc_enable_q;
  wire meas_wrap = running & cr_tick & (meas_q == `RFC_CNT_MAX);
  wire tb_wrap   = st_ref & op_tick & (tb_q == `RFC_CNT_MAX);
  wire tb_zero   = st_sens & op_tick & (tb_q == `RFC_CNT_ONE);
  wire stop_now  = auto_stop_ok &
                   (st_ref ? (meas_wrap | tb_wrap) : (tb_zero | meas_wrap));
  wire start_b_ok = oscillation_mode_sel_q != rfc_pkg::MODE_AC;

  assign converter_enable_d = wr_ctl ? i_pwdata[`RFC_EN_BIT]
                                     : converter_enable_q;

  // Trigger state: a write overrides any automatic stop in the same cycle
  always_comb
  begin
    state_d = state_q;
    if (!converter_enable_d)
      state_d = rfc_pkg::ST_IDLE;
    else if (wr_trg && converter_enable_q)
    begin
      // Lowest trigger bit wins if software breaks the one-bit convention
      if (i_pwdata[`RFC_REF_BIT])
        state_d = rfc_pkg::ST_REF;
      else if (i_pwdata[`RFC_SENA_BIT])
        state_d = rfc_pkg::ST_SENS_A;
      else if (i_pwdata[`RFC_SENB_BIT] && start_b_ok)
        state_d = rfc_pkg::ST_SENS_B;
      else
        state_d = rfc_pkg::ST_IDLE;
    end
    else if (stop_now)
      state_d = rfc_pkg::ST_IDLE;
  end

  wire start_ref  = (state_d == rfc_pkg::ST_REF) & ~st_ref;
  wire start_sens = ((state_d == rfc_pkg::ST_SENS_A) & ~st_sa) |
                    ((state_d == rfc_pkg::ST_SENS_B) & ~st_sb);

  // Counters: software writes take priority over counting
  always_comb
  begin
    meas_d = meas_q;
    if (wr_mcl)
      meas_d = {meas_q[23:16], i_pwdata[15:0]};
    else if (wr_mch)
      meas_d = {i_pwdata[7:0], meas_q[15:0]};
    else if (start_sens)
      meas_d = `RFC_CNT_ZERO;
    else if (running && cr_tick)
      meas_d = meas_q + `RFC_CNT_ONE;
  end

  always_comb
  begin
    tb_d = tb_q;
    if (wr_tcl)
      tb_d = {tb_q[23:16], i_pwdata[15:0]};
    else if (wr_tch)
      tb_d = {i_pwdata[7:0], tb_q[15:0]};
    else if (start_ref)
      tb_d = `RFC_CNT_ZERO;
    else if (st_ref && op_tick)
      tb_d = tb_q + `RFC_CNT_ONE;
    else if (st_sens && op_tick)
      tb_d = tb_q - `RFC_CNT_ONE;
  end

  // Cause flags
  assign flag_set[`RFC_REF_BIT]  = st_ref & meas_wrap & auto_stop_ok;
  assign flag_set[`RFC_OVTC_BIT] = tb_wrap & auto_stop_ok;
  assign flag_set[`RFC_SENA_BIT] = st_sa & tb_zero & auto_stop_ok;
  assign flag_set[`RFC_SENB_BIT] = st_sb & tb_zero & auto_stop_ok;
  assign flag_set[`RFC_OVMC_BIT] = st_sens & meas_wrap & auto_stop_ok;

  genvar g;
  generate
    for (g = 0; g < `RFC_NFLAGS; g = g + 1)
    begin : g_flag
      // A hardware set wins over a clear written in the same cycle
      wire clr = wr_intf & i_pwdata[g];
      always_ff @(posedge i_clk)
      begin
        if (!i_reset_n)
          flags_q[g] <= 1'b0;
        else
          flags_q[g] <= flag_set[g] | (flags_q[g] & ~clr);
      end
    end
  endgenerate

  // Read mux, captured in the setup phase
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (sel_clk)
      rd_d = {23'h0, debug_run_enable_q, 2'h0, clock_divider_sel_q,
              2'h0, clock_source_sel_q};
    else if (sel_ctl)
      rd_d = {23'h0, monitor_half_rate_q, continuous_osc_enable_q,
              event_count_enable_q, oscillation_mode_sel_q, 3'h0,
              converter_enable_q};
    else if (sel_trg)
      rd_d = {29'h0, st_sb, st_sa, st_ref};
    else if (sel_mcl)
      rd_d = {16'h0, meas_q[15:0]};
    else if (sel_mch)
      rd_d = {24'h0, meas_q[23:16]};
    else if (sel_tcl)
      rd_d = {16'h0, tb_q[15:0]};
    else if (sel_tch)
      rd_d = {24'h0, tb_q[23:16]};
    else if (sel_intf)
      rd_d = {27'h0, flags_q};
    else if (sel_inte)
      rd_d = {27'h0, int_en_q};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      debug_run_enable_q  <= `RFC_DEBUG_RUN_ENABLE_RST;
      clock_divider_sel_q <= 2'h0;
      clock_source_sel_q  <= rfc_pkg::SRC_INTERNAL;
    end
    else if (wr_clk)
    begin
      debug_run_enable_q  <= i_pwdata[`RFC_DEBUG_RUN_ENABLE_BIT];
      clock_divider_sel_q <= i_pwdata[`RFC_DIV_LSB +: 2];
      clock_source_sel_q  <= rfc_pkg::clk_src_t'(i_pwdata[`RFC_SRC_LSB +: 2]);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      monitor_half_rate_q     <= 1'b0;
      continuous_osc_enable_q <= 1'b0;
      event_count_enable_q    <= 1'b0;
      oscillation_mode_sel_q  <= rfc_pkg::MODE_DC;
      converter_enable_q      <= 1'b0;
    end
    else if (wr_ctl)
    begin
      monitor_half_rate_q     <= i_pwdata[`RFC_MONHALF_BIT];
      continuous_osc_enable_q <= i_pwdata[`RFC_CONT_BIT];
      event_count_enable_q    <= i_pwdata[`RFC_EVT_BIT];
      oscillation_mode_sel_q  <=
        rfc_pkg::osc_mode_t'(i_pwdata[`RFC_OSCILLATION_MODE_SEL_LSB +: 2]);
      converter_enable_q      <= converter_enable_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state_q  <= rfc_pkg::ST_IDLE;
      meas_q   <= `RFC_CNT_ZERO;
      tb_q     <= `RFC_CNT_ZERO;
      int_en_q <= '0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      state_q  <= state_d;
      meas_q   <= meas_d;
      tb_q     <= tb_d;
      int_en_q <= wr_inte ? i_pwdata[`RFC_NFLAGS-1:0] : int_en_q;
      prdata_q <= setup ? rd_d : prdata_q;
    end
  end

  // Divider restarts whenever the clock is withheld, so ratios stay aligned
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      div_q <= 3'h0;
    else if (!clk_run)
      div_q <= 3'h0;
    else if (src_tick)
      div_q <= div_q + 3'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      cr_prev_q  <= 1'b0;
      half_q     <= 1'b0;
      monitor_q  <= 1'b0;
      drive_q    <= '0;
      pulldown_q <= 1'b0;
      irq_q      <= 1'b0;
    end
    else
    begin
      cr_prev_q  <= cr_level;
      half_q     <= cr_tick ? ~half_q : half_q;
      monitor_q  <= monitor_half_rate_q ? half_q : cr_level;
      drive_q    <= '{sensor_b:  state_d == rfc_pkg::ST_SENS_B,
                      sensor_a:  state_d == rfc_pkg::ST_SENS_A,
                      reference: state_d == rfc_pkg::ST_REF};
      pulldown_q <= i_pin_func_sel;
      irq_q      <= |(flags_q & int_en_q);
    end
  end

  assign o_osc_monitor  = monitor_q;
  assign o_osc_drive    = drive_q;
  assign o_pin_pulldown = pulldown_q;
  assign o_irq          = irq_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_div8_cfg;
    op_tick && clock_source_sel_q == rfc_pkg::SRC_INTERNAL &&
    clock_divider_sel_q == 2'h3;
  endsequence
  sequence s_quiet7;
    !op_tick [*7];
  endsequence

  a_debug_gate: assert property (
    i_debug_mode && !debug_run_enable_q |-> !op_tick)
    else $error("operating clock ran in debug mode");
  a_div_eight: assert property (s_div8_cfg |=> s_quiet7)
    else $error("divide-by-8 ticked early");
  a_monitor_full: assert property (
    !monitor_half_rate_q ##1 !$changed(monitor_half_rate_q)
    |-> o_osc_monitor == $past(cr_level))
    else $error("monitor pin not following oscillation clock");
  a_cont_hold: assert property (
    continuous_osc_enable_q && running && !wr_trg && !wr_ctl
    |=> state_q == $past(state_q))
    else $error("oscillation stopped in continuous mode");
  a_event_src: assert property (
    event_count_enable_q && !cr_prev_q && i_converter_pin && clk_run
    |-> cr_tick)
    else $error("external pin edge not counted");
  a_disabled_idle: assert property (!converter_enable_q |-> !running)
    else $error("oscillation while converter disabled");
  a_sensb_ac: assert property (
    wr_trg && oscillation_mode_sel_q == rfc_pkg::MODE_AC && !st_sb
    |=> !st_sb)
    else $error("sensor B started in AC mode");
  a_ref_done: assert property (
    st_ref && meas_wrap && auto_stop_ok && !wr_trg && !wr_ctl
    |=> !st_ref && flags_q[`RFC_REF_BIT] && meas_q == `RFC_CNT_ZERO)
    else $error("reference wrap did not finish run");
  a_sens_done: assert property (
    st_sa && tb_zero && auto_stop_ok && !wr_trg && !wr_ctl
    |=> !running && flags_q[`RFC_SENA_BIT] && tb_q == `RFC_CNT_ZERO)
    else $error("sensor A did not finish at zero");
  a_flag_clear: assert property (
    wr_intf && i_pwdata[`RFC_OVTC_BIT] && !flag_set[`RFC_OVTC_BIT]
    |=> !flags_q[`RFC_OVTC_BIT])
    else $error("flag not cleared by writing one");
  a_irq_gate: assert property (
    ##1 o_irq == $past(|(flags_q & int_en_q)))
    else $error("interrupt request does not match enabled flags");
  a_reserved_zero: assert property (
    sel_trg && setup |=> o_prdata[31:3] == 29'h0)
    else $error("reserved trigger bits read nonzero");

endmodule : resistance_freq_converter

`default_nettype wire

/* common/rfc_regs.svh */
// Register map, field positions and reset values of one converter channel.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef RFC_REGS_SVH
`define RFC_REGS_SVH

`define RFC_ADDR_W          8
`define RFC_OFF_CLOCK_CFG   8'h00
`define RFC_OFF_CONV_CTL    8'h04
`define RFC_OFF_OSC_TRIG    8'h08
`define RFC_OFF_MEAS_LOW    8'h0C
`define RFC_OFF_MEAS_HIGH   8'h10
`define RFC_OFF_TB_LOW      8'h14
`define RFC_OFF_TB_HIGH     8'h18
`define RFC_OFF_INT_FLAGS   8'h1C
`define RFC_OFF_INT_ENABLES 8'h20

// clock_config fields
`define RFC_DEBUG_RUN_ENABLE_BIT       8
`define RFC_DEBUG_RUN_ENABLE_RST       1'h1
`define RFC_DIV_LSB         4
`define RFC_SRC_LSB         0
// converter_control fields
`define RFC_MONHALF_BIT     8
`define RFC_CONT_BIT        7
`define RFC_EVT_BIT         6
`define RFC_OSCILLATION_MODE_SEL_LSB       4
`define RFC_EN_BIT          0
// oscillation_trigger and flag bits
`define RFC_REF_BIT         0
`define RFC_SENA_BIT        1
`define RFC_SENB_BIT        2
`define RFC_OVMC_BIT        3
`define RFC_OVTC_BIT        4
`define RFC_NFLAGS          5

`define RFC_CNT_MAX         24'hFFFFFF
`define RFC_CNT_ONE         24'h000001
`define RFC_CNT_ZERO        24'h000000
`define RFC_DIV_MASK1       3'h0
`define RFC_DIV_MASK2       3'h1
`define RFC_DIV_MASK4       3'h3
`define RFC_DIV_MASK8       3'h7

`endif

/* common/rfc_pkg.sv */
// Types shared by the converter channel and its bench.
// Assumes rfc_regs.svh for numeric constants.
`default_nettype none

package rfc_pkg;
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00, SRC_LOW_SPEED = 2'b01,
    SRC_HIGH_SPEED = 2'b10, SRC_EXTERNAL = 2'b11
  } clk_src_t;
  typedef enum logic [1:0] {
    MODE_DC = 2'b00, MODE_AC = 2'b01, MODE_RSV2 = 2'b10, MODE_RSV3 = 2'b11
  } osc_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_REF = 2'b01, ST_SENS_A = 2'b10, ST_SENS_B = 2'b11
  } run_state_t;
  typedef struct packed {
    logic sensor_b;
    logic sensor_a;
    logic reference;
  } osc_drive_t;
endpackage : rfc_pkg

`default_nettype wire

/* bench/rc_network_model.sv */
// Behavioural sensor and reference RC network on the far side.
// Assumes the oscillator enables are registered in the i_clk domain.
`timescale 1ns/1ns
`default_nettype none

module rc_network_model (
  input  wire logic                i_clk,
  input  wire logic                i_reset_n,
  input  wire rfc_pkg::osc_drive_t i_drive,
  input  wire logic [3:0]          i_half,
  output logic                     o_cr_osc
);
  logic [3:0] cnt_q;

  // The network only swings while some oscillator is enabled; else it rests
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || i_drive == 3'h0)
    begin
      cnt_q    <= 4'h0;
      o_cr_osc <= 1'b0;
    end
    else if (cnt_q + 4'h1 >= i_half)
    begin
      cnt_q    <= 4'h0;
      o_cr_osc <= !o_cr_osc;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule : rc_network_model

`default_nettype wire

/* bench/resistance_freq_converter_tb_top.sv */
// Self-checking bench for one converter channel over APB.
// Assumes zero-wait APB and the RC model answering on the drive outputs.
`timescale 1ns/1ns
`include "rfc_regs.svh"
`default_nettype none

module resistance_freq_converter_tb_top;
  logic clk, rst_n, psel, pen, pwr, func_sel, cr, itick;
  logic dbg, pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, mon, pd, irq, er;
  logic [3:0] half;
  rfc_pkg::osc_drive_t drive;
  int err_total, check_count, cycles;

  resistance_freq_converter dut (.i_clk(clk), .i_reset_n(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_debug_mode(dbg), .i_internal_osc_tick(itick),
    .i_low_speed_osc_tick(1'b0), .i_high_speed_osc_tick(1'b0),
    .i_ext_clock_tick(1'b0), .i_cr_osc(cr), .i_converter_pin(pin),
    .i_pin_func_sel(func_sel), .o_osc_monitor(mon), .o_osc_drive(drive),
    .o_pin_pulldown(pd), .o_irq(irq));
  rc_network_model rc (.i_clk(clk), .i_reset_n(rst_n), .i_drive(drive),
    .i_half(half), .o_cr_osc(cr));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  // Covers the whole sequence with wide margin
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
  begin
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // Only the bench timeout ends a wait for pready
    while (pready !== 1'b1)
      @(posedge clk);
    rd   = prdata;
    er   = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdc

  // Polls the trigger register until the run has stopped by itself
  task automatic wait_idle;
    int n;
  begin
    n = 0;
    rd = 32'h0000_0001;
    while (rd !== 32'h0000_0000 && n < 100)
    begin
      apb(1'b0, `RFC_OFF_OSC_TRIG, 32'h0000_0000);
      n++;
    end
    chk("run stopped", 32'h0000_0000, rd);
  end
  endtask : wait_idle

  task automatic toggles(input int e);
    int n;
    logic p;
  begin
    n = 0;
    // Skip the edge that may still carry the previous monitor mode
    repeat (2) @(negedge clk);
    p = mon;
    repeat (8)
    begin
      @(negedge clk);
      if (mon !== p)
        n++;
      p = mon;
    end
    chk("monitor edges", e, n);
  end
  endtask : toggles

  task automatic t_reset_values;
    rdc(`RFC_OFF_CLOCK_CFG, 32'h0000_0100, "clock_config");
    rdc(`RFC_OFF_CONV_CTL, 32'h0000_0000, "converter_control");
    rdc(`RFC_OFF_OSC_TRIG, 32'h0000_0000, "oscillation_trigger");
    rdc(`RFC_OFF_MEAS_LOW, 32'h0000_0000, "meas_count_low");
    rdc(`RFC_OFF_MEAS_HIGH, 32'h0000_0000, "meas_count_high");
    rdc(`RFC_OFF_TB_LOW, 32'h0000_0000, "timebase_count_low");
    rdc(`RFC_OFF_TB_HIGH, 32'h0000_0000, "timebase_count_high");
    rdc(`RFC_OFF_INT_FLAGS, 32'h0000_0000, "interrupt_flags");
    rdc(8'h24, 32'h0000_0000, "unmapped read");
    chk("unmapped error", 32'h1, er);
  endtask : t_reset_values

  task automatic t_config;
    wr(`RFC_OFF_CLOCK_CFG, 32'hFFFF_FFFF);
    rdc(`RFC_OFF_CLOCK_CFG, 32'h0000_0133, "clock_config all");
    wr(`RFC_OFF_CLOCK_CFG, 32'h0000_0000);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0001);
    rdc(`RFC_OFF_OSC_TRIG, 32'h0000_0000, "trigger disabled");
    wr(`RFC_OFF_CONV_CTL, 32'hFFFF_FFFE);
    rdc(`RFC_OFF_CONV_CTL, 32'h0000_01F0, "control all");
    wr(`RFC_OFF_CONV_CTL, 32'h0000_0001);
    wr(`RFC_OFF_CLOCK_CFG, 32'h0000_0011);
    rdc(`RFC_OFF_CLOCK_CFG, 32'h0000_0000, "clock_config locked");
    func_sel <= 1'b1;
    repeat (2) @(posedge clk);
    chk("pulldown", 32'h1, pd);
  endtask : t_config

  task automatic t_counters;
    wr(`RFC_OFF_MEAS_LOW, 32'hFFFF_ABCD);
    wr(`RFC_OFF_MEAS_HIGH, 32'hFFFF_FF5A);
    rdc(`RFC_OFF_MEAS_LOW, 32'h0000_ABCD, "meas low");
    rdc(`RFC_OFF_MEAS_HIGH, 32'h0000_005A, "meas high");
    wr(`RFC_OFF_TB_LOW, 32'h0000_1234);
    wr(`RFC_OFF_TB_HIGH, 32'h0000_0A07);
    rdc(`RFC_OFF_TB_LOW, 32'h0000_1234, "timebase low");
    rdc(`RFC_OFF_TB_HIGH, 32'h0000_0007, "timebase high");
  endtask : t_counters

  task automatic t_reference;
    half <= 4'h1;
    wr(`RFC_OFF_INT_ENABLES, 32'hFFFF_FFFF);
    rdc(`RFC_OFF_INT_ENABLES, 32'h0000_001F, "interrupt_enables");
    wr(`RFC_OFF_MEAS_LOW, 32'h0000_FFFC);
    wr(`RFC_OFF_MEAS_HIGH, 32'h0000_00FF);
    wr(`RFC_OFF_INT_FLAGS, 32'h0000_001F);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0001);
    @(negedge clk);
    chk("drive ref", 32'h1, drive);
    wait_idle();
    rdc(`RFC_OFF_INT_FLAGS, 32'h0000_0001, "ref done flag");
    rdc(`RFC_OFF_MEAS_HIGH, 32'h0000_0000, "meas wrapped");
    chk("irq on", 32'h1, irq);
    wr(`RFC_OFF_INT_FLAGS, 32'h0000_0001);
    rdc(`RFC_OFF_INT_FLAGS, 32'h0000_0000, "flag cleared");
    chk("irq off", 32'h0, irq);
  endtask : t_reference

  task automatic t_sensor_a;
    half <= 4'h3;
    wr(`RFC_OFF_TB_LOW, 32'h0000_0010);
    wr(`RFC_OFF_TB_HIGH, 32'h0000_0000);
    wr(`RFC_OFF_INT_FLAGS, 32'h0000_001F);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0002);
    @(negedge clk);
    chk("drive sensor a", 32'h2, drive);
    wait_idle();
    rdc(`RFC_OFF_INT_FLAGS, 32'h0000_0002, "sensor a flag");
    rdc(`RFC_OFF_TB_LOW, 32'h0000_0000, "timebase at zero");
    rdc(`RFC_OFF_MEAS_HIGH, 32'h0000_0000, "meas from zero");
    wr(`RFC_OFF_INT_FLAGS, 32'h0000_001F);
  endtask : t_sensor_a

  task automatic t_sensor_b;
    wr(`RFC_OFF_CONV_CTL, 32'h0000_0011);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0004);
    rdc(`RFC_OFF_OSC_TRIG, 32'h0000_0000, "sensor b in ac");
    wr(`RFC_OFF_CONV_CTL, 32'h0000_0001);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0004);
    rdc(`RFC_OFF_OSC_TRIG, 32'h0000_0004, "sensor b in dc");
    chk("drive sensor b", 32'h4, drive);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0000);
    rdc(`RFC_OFF_OSC_TRIG, 32'h0000_0000, "sensor b stop");
  endtask : t_sensor_b

  task automatic t_continuous;
    half <= 4'h1;
    wr(`RFC_OFF_CONV_CTL, 32'h0000_0081);
    wr(`RFC_OFF_MEAS_LOW, 32'h0000_FFFE);
    wr(`RFC_OFF_MEAS_HIGH, 32'h0000_00FF);
    wr(`RFC_OFF_INT_FLAGS, 32'h0000_001F);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0001);
    repeat (60) @(posedge clk);
    rdc(`RFC_OFF_OSC_TRIG, 32'h0000_0001, "still running");
    rdc(`RFC_OFF_INT_FLAGS, 32'h0000_0000, "no stop flag");
    toggles(8);
    wr(`RFC_OFF_CONV_CTL, 32'h0000_0181);
    toggles(4);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0000);
    rdc(`RFC_OFF_OSC_TRIG, 32'h0000_0000, "software stop");
  endtask : t_continuous

  // Divide-by-8 clock withheld in debug, then the pin as event clock
  task automatic t_debug_event;
    logic [31:0] v;
  begin
    wr(`RFC_OFF_CONV_CTL, 32'h0000_0000);
    wr(`RFC_OFF_CLOCK_CFG, 32'h0000_0030);
    wr(`RFC_OFF_CONV_CTL, 32'h0000_0001);
    wr(`RFC_OFF_INT_FLAGS, 32'h0000_001F);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0001);
    repeat (20) @(posedge clk);
    dbg <= 1'b1;
    apb(1'b0, `RFC_OFF_TB_LOW, 32'h0000_0000);
    v = rd;
    repeat (20) @(posedge clk);
    rdc(`RFC_OFF_TB_LOW, v, "timebase held in debug");
    dbg <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b0, `RFC_OFF_TB_LOW, 32'h0000_0000);
    chk("timebase runs", 32'h1, rd != v);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0000);
    wr(`RFC_OFF_CONV_CTL, 32'h0000_0041);
    wr(`RFC_OFF_MEAS_LOW, 32'h0000_FFFD);
    wr(`RFC_OFF_MEAS_HIGH, 32'h0000_00FF);
    wr(`RFC_OFF_INT_FLAGS, 32'h0000_001F);
    wr(`RFC_OFF_OSC_TRIG, 32'h0000_0001);
    repeat (3)
    begin
      pin <= 1'b1;
      repeat (2) @(posedge clk);
      pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
    wait_idle();
    rdc(`RFC_OFF_INT_FLAGS, 32'h0000_0001, "event count done");
  end
  endtask : t_debug_event

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  initial
  begin
    {rst_n, psel, pen, pwr, func_sel, dbg, pin} = 7'h00;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    half   = 4'h1;
    itick  = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_config();
    t_counters();
    t_reference();
    t_sensor_a();
    t_sensor_b();
    t_continuous();
    t_debug_event();
    give_verdict();
  end
endmodule : resistance_freq_converter_tb_top

`default_nettype wire
